// ===== verilog/ftm_map.svh
// Register map, field positions, reset values and timing figures of the
// FSK tone modulator. Assumes it is included by bare name.
`ifndef FTM_MAP_SVH
`define FTM_MAP_SVH

// Register byte offsets
`define FTM_CTRL_OFS     12'h000
`define FTM_STATUS_OFS   12'h004
`define FTM_TC_HM_OFS    12'h008
`define FTM_TC_HS_OFS    12'h00c
`define FTM_CLRCNT_OFS   12'h010

// Control fields
`define FTM_CTRL_ENABLE  0
`define FTM_CTRL_ORIG    1
`define FTM_CTRL_SPACE   2
`define FTM_CTRL_RESET   3'h0

// Status fields
`define FTM_ST_LATCH     9
`define FTM_ST_DIV2      10
`define FTM_ST_TONE      11

// Terminal counts
`define FTM_TC_LM        9'h18a
`define FTM_TC_LS        9'h1d3
`define FTM_TC_HM_RESET  9'h0e1
`define FTM_TC_HS_RESET  9'h0f7

// Clock rates and the clear pulse limit
`define FTM_PCLK_HZ      26'd50000000
`define FTM_XTAL_HZ      26'd1000640
`define FTM_PCLK_NS      20
`define FTM_CLR_MAX_NS   100
`define FTM_CLR_CYCLES   (`FTM_CLR_MAX_NS / `FTM_PCLK_NS)

`endif

// ===== verilog/ftm_pkg.sv
// Types shared by the FSK tone modulator files.
// Assumes nothing beyond a SystemVerilog compiler.
package ftm_pkg;

    // Count step sequencer: wait for tick, settle, decode
    typedef enum logic [2:0] {
        FTM_WAIT   = 3'b001,
        FTM_SETTLE = 3'b010,
        FTM_DECODE = 3'b100
    } ftm_state_e;

    typedef logic [8:0] ftm_count_t;

endpackage

// ===== verilog/ftm_xtal_tick.sv
// Crystal rate enable: one pclk pulse per crystal clock period.
// Assumes a single free-running pclk at the rate given in the map.
`timescale 1ns/1ps
`default_nettype none
`include "ftm_map.svh"

module ftm_xtal_tick
    import ftm_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Crystal rate pulse
    output logic      tick
);

    logic [25:0] acc;
    wire  [26:0] sum  = {1'b0, acc} + {1'b0, `FTM_XTAL_HZ};
    wire         wrap = sum >= {1'b0, `FTM_PCLK_HZ};

    // Fractional accumulator, pulses on each wrap
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc  <= 26'h0;
            tick <= 1'b0;
        end
        else
        begin
            acc  <= wrap ? sum[25:0] - `FTM_PCLK_HZ : sum[25:0];
            tick <= wrap;
        end
    end

endmodule // ftm_xtal_tick
`default_nettype wire

// ===== verilog/ftm_decoder.sv
// One count decoder: a one-cycle hit when the counter equals its
// terminal count, only in the decode window and only while enabled.
// Assumes the counter is stable while strobe is high.
`timescale 1ns/1ps
`default_nettype none

module ftm_decoder
    import ftm_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Compare inputs
    input  wire ftm_count_t count,
    input  wire ftm_count_t tc,
    input  wire logic       enable,
    input  wire logic       strobe,
    // Match pulse
    output logic            hit
);

    // All nine bits compared, gated by enable and decode window
    wire match = enable & strobe & (count == tc);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hit <= 1'b0;
        else
            hit <= match;
    end

endmodule // ftm_decoder
`default_nettype wire

// ===== verilog/ftm_modulator.sv
// FSK tone modulator with an APB register slave.
// Assumes an APB master on pclk; the tone output feeds the line filters.
//
// What this block does
// - Crystal-rate ticks advance a nine-bit counter dividing every tone.
// - Four decoders compare all nine counter bits to their own counts.
// - Decoders are blanked while the inhibit pulse lets the counter settle.
// - Originate enables low-band decoders only; answer enables high-band only.
// - Data high means space and enables the spacing decoders only then.
// - Low mark decoder fires at 394, setting the latch; mark then clears.
// - Clear zeroes the counter, toggles the divider, resets latch; one cycle.
// - Held mark repeats count to 394 and clear, giving 1270 Hz.
// - Held space ignores 394 and clears at 467, giving 1070 Hz.
// - Latch sets at 394 during space; a later mark clears at once.
// - Line tone output is the inverse of the divider flip-flop.
// - Originate sends low band; answer sends 2025 or 2225 Hz tones at the reset counts.
`timescale 1ns/1ps
`default_nettype none
`include "ftm_map.svh"

module ftm_modulator
    import ftm_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Line side
    output logic             tone_out,
    output logic             decode_inhibit_pulse
);

    // Control and configuration state
    logic        ctrl_enable;
    logic        ctrl_orig;
    logic        ctrl_space;
    ftm_count_t  tc_hm;
    ftm_count_t  tc_hs;
    logic [15:0] clr_count;

    // Tone engine state
    ftm_state_e  state;
    ftm_state_e  next_state;
    ftm_count_t  count;
    logic        mark_latch;
    logic        tick;
    logic        lm_hit;
    logic        ls_hit;
    logic        hm_hit;
    logic        hs_hit;

    // APB phase decode
    wire setup_ph   = psel & ~penable;
    wire access_ph  = psel & penable;
    wire wr_fire    = access_ph & pready & pwrite;
    wire sel_ctrl   = paddr == `FTM_CTRL_OFS;
    wire sel_status = paddr == `FTM_STATUS_OFS;
    wire sel_tc_hm  = paddr == `FTM_TC_HM_OFS;
    wire sel_tc_hs  = paddr == `FTM_TC_HS_OFS;
    wire sel_clrcnt = paddr == `FTM_CLRCNT_OFS;
    wire sel_any    = sel_ctrl | sel_status | sel_tc_hm | sel_tc_hs | sel_clrcnt;

    // Read data mux
    wire [31:0] status_word = {20'h0, tone_out, ~tone_out, mark_latch, count};
    wire [31:0] rd_mux =
        sel_ctrl   ? {29'h0, ctrl_space, ctrl_orig, ctrl_enable} :
        sel_status ? status_word :
        sel_tc_hm  ? {23'h0, tc_hm} :
        sel_tc_hs  ? {23'h0, tc_hs} :
        sel_clrcnt ? {16'h0, clr_count} :
        32'h0;

    // Decoder enables from band and data
    wire lm_en = ctrl_enable & ctrl_orig;
    wire ls_en = ctrl_enable & ctrl_orig & ctrl_space;
    wire hm_en = ctrl_enable & ~ctrl_orig;
    wire hs_en = ctrl_enable & ~ctrl_orig & ctrl_space;

    // Decode window opens only after the settle cycle
    wire dec_strobe = state == FTM_DECODE;

    // Mark latch set and the counter clear
    wire mark_hit  = lm_hit | hm_hit;
    wire space_hit = ls_hit | hs_hit;
    wire mark_go   = mark_latch & ~ctrl_space;
    wire clr_fire  = ctrl_enable & (mark_go | space_hit);

    // Latch: a new set wins over the clear of the same cycle
    wire next_latch = ctrl_enable & (mark_hit | (mark_latch & ~clr_fire));

    // Sequencer next state
    always_comb
    begin
        next_state = state;
        unique case (state)
            FTM_WAIT:
            begin
                if (tick & ctrl_enable & ~clr_fire)
                    next_state = FTM_SETTLE;
            end
            FTM_SETTLE:
                next_state = FTM_DECODE;
            FTM_DECODE:
                next_state = FTM_WAIT;
        endcase
    end

    // Crystal rate enable
    ftm_xtal_tick u_tick (
        .clk   (pclk),
        .rst_n (presetn),
        .tick  (tick)
    );

    // Low-band mark decoder
    ftm_decoder u_dec_lm (
        .clk    (pclk),
        .rst_n  (presetn),
        .count  (count),
        .tc     (`FTM_TC_LM),
        .enable (lm_en),
        .strobe (dec_strobe),
        .hit    (lm_hit)
    );

    // Low-band space decoder
    ftm_decoder u_dec_ls (
        .clk    (pclk),
        .rst_n  (presetn),
        .count  (count),
        .tc     (`FTM_TC_LS),
        .enable (ls_en),
        .strobe (dec_strobe),
        .hit    (ls_hit)
    );

    // High-band mark decoder
    ftm_decoder u_dec_hm (
        .clk    (pclk),
        .rst_n  (presetn),
        .count  (count),
        .tc     (tc_hm),
        .enable (hm_en),
        .strobe (dec_strobe),
        .hit    (hm_hit)
    );

    // High-band space decoder
    ftm_decoder u_dec_hs (
        .clk    (pclk),
        .rst_n  (presetn),
        .count  (count),
        .tc     (tc_hs),
        .enable (hs_en),
        .strobe (dec_strobe),
        .hit    (hs_hit)
    );

    // APB answer: no wait states, data and error registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
        else
        begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~sel_any;
            prdata  <= setup_ph ? rd_mux : 32'h0;
        end
    end

    // Control register writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {ctrl_space, ctrl_orig, ctrl_enable} <= `FTM_CTRL_RESET;
        end
        else if (wr_fire & sel_ctrl)
        begin
            ctrl_enable <= pwdata[`FTM_CTRL_ENABLE];
            ctrl_orig   <= pwdata[`FTM_CTRL_ORIG];
            ctrl_space  <= pwdata[`FTM_CTRL_SPACE];
        end
    end

    // High-band terminal count writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tc_hm <= `FTM_TC_HM_RESET;
            tc_hs <= `FTM_TC_HS_RESET;
        end
        else if (wr_fire)
        begin
            if (sel_tc_hm)
                tc_hm <= pwdata[8:0];
            if (sel_tc_hs)
                tc_hs <= pwdata[8:0];
        end
    end

    // Sequencer register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= FTM_WAIT;
        else
            state <= next_state;
    end

    // Nine-stage counter: clear beats a step
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count <= 9'h0;
        else if (clr_fire | ~ctrl_enable)
            count <= 9'h0;
        else if (state == FTM_WAIT && tick)
            count <= count + 9'h1;
    end

    // Inhibit pulse marks the settle cycle after each step
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            decode_inhibit_pulse <= 1'b0;
        else
            decode_inhibit_pulse <= next_state == FTM_SETTLE;
    end

    // Pending-mark latch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mark_latch <= 1'b0;
        else
            mark_latch <= next_latch;
    end

    // Line tone: inverse of the divide-by-two stage, which resets low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tone_out <= 1'b1;
        else if (clr_fire)
            tone_out <= ~tone_out;
    end

    // Count of clears, wraps, readable for tone checks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clr_count <= 16'h0;
        else if (clr_fire)
            clr_count <= clr_count + 16'h1;
    end

endmodule // ftm_modulator
`default_nettype wire

// ===== verification/ftm_checker.sv
// Port assertions for the tone modulator.
// Assumes it is bound onto ftm_modulator.
`timescale 1ns/1ps
`default_nettype none
module ftm_checker
(
    // Clock, reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Line
    input wire logic        tone_out,
    input wire logic        decode_inhibit_pulse
);
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    // APB answer timing
    AST_RDY_ONE: assert property (pready |=> !pready) else $error("long pready");
    AST_RDY_LAT: assert property (psel && !penable |-> ##1 pready) else $error("late pready");
    AST_RDY_SEL: assert property (pready |-> psel && penable) else $error("stray pready");
    AST_ERR_RDY: assert property (pslverr |-> pready) else $error("stray pslverr");
    AST_RD_IDLE: assert property (!pready |-> prdata == 32'h0) else $error("stray prdata");
    // Tone engine
    AST_TICK_GAP: assert property (decode_inhibit_pulse |=> !decode_inhibit_pulse[*8])
        else $error("inhibit too often");
    AST_TONE_HOLD: assert property ($changed(tone_out) |=> $stable(tone_out)[*8])
        else $error("tone toggled twice");
    AST_TONE_RST: assert property ($rose(presetn) |-> tone_out)
        else $error("tone not idle high");
endmodule // ftm_checker
bind ftm_modulator ftm_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tone_out(tone_out),
    .decode_inhibit_pulse(decode_inhibit_pulse)
);
`default_nettype wire

// ===== verification/ftm_line_monitor.sv
// Line-side model: times each level of the tone sent to the filters.
// Assumes tone_out is sampled on pclk.
`timescale 1ns/1ps
`default_nettype none
module ftm_line_monitor
(
    // Clock, reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Tone from the modulator
    input  wire logic tone_out,
    // Measurements
    output var  int   half_cycles,
    output var  int   toggles
);
    int   run;
    logic last;
    // Cycles per tone level and number of level changes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run <= 0;
            last <= 1'b1;
            half_cycles <= 0;
            toggles <= 0;
        end
        else if (tone_out != last)
        begin
            half_cycles <= run + 1;
            run <= 0;
            toggles <= toggles + 1;
            last <= tone_out;
        end
        else
            run <= run + 1;
    end
endmodule // ftm_line_monitor
`default_nettype wire

// ===== verification/fsk_tone_modulator_bench.sv
// Self-checking bench for the tone modulator.
// Assumes the register map header and a 50 MHz pclk.
`timescale 1ns/1ps
`default_nettype none
`include "ftm_map.svh"
module fsk_tone_modulator_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, tone_out, decode_inhibit_pulse, err;
    int          half_cycles, toggles, t0;
    int          num_errors = 0;
    int          checked = 0;

    // 20 ns clock
    always #10 pclk = ~pclk;

    ftm_modulator u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tone_out(tone_out), .decode_inhibit_pulse(decode_inhibit_pulse));
    ftm_line_monitor u_line (.pclk(pclk), .presetn(presetn), .tone_out(tone_out),
        .half_cycles(half_cycles), .toggles(toggles));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_near(input string what, input int exp, input int got);
        checked++;
        if (got < exp - 3 || got > exp + 3)
        begin
            num_errors++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        chk("pready", 32'h1, {31'h0, pready});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Wait n toggles, then compare the last level time with the tick count
    task automatic gap(input int ticks, input int n);
        t0 = toggles;
        for (int i = 0; i < 40000 && toggles < t0 + n; i++)
            @(negedge pclk);
        chk_near("half period", int'(longint'(ticks) * `FTM_PCLK_HZ / `FTM_XTAL_HZ), half_cycles);
    endtask

    task automatic t_regs();
        apb(1'b0, `FTM_TC_HM_OFS, 32'h0);
        chk("tc_hm reset", {23'h0, `FTM_TC_HM_RESET}, rd);
        apb(1'b0, `FTM_TC_HS_OFS, 32'h0);
        chk("tc_hs reset", {23'h0, `FTM_TC_HS_RESET}, rd);
        apb(1'b1, `FTM_STATUS_OFS, 32'hffff_ffff);
        apb(1'b0, `FTM_STATUS_OFS, 32'h0);
        chk("status idle", 32'h1 << `FTM_ST_TONE, rd);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        $display("t_regs done");
    endtask

    task automatic t_high();
        apb(1'b1, `FTM_TC_HM_OFS, 32'h14);
        apb(1'b1, `FTM_TC_HS_OFS, 32'h1e);
        apb(1'b1, `FTM_CTRL_OFS, 32'h1);
        gap(20, 2);
        apb(1'b1, `FTM_CTRL_OFS, 32'h5);
        gap(30, 1);
        apb(1'b0, `FTM_STATUS_OFS, 32'h0);
        chk("divider", {31'h0, toggles[0]}, {31'h0, rd[`FTM_ST_DIV2]});
        chk("tone level", {31'h0, ~toggles[0]}, {31'h0, tone_out});
        $display("t_high done");
    endtask

    task automatic t_low();
        apb(1'b1, `FTM_CTRL_OFS, 32'h3);
        gap(394, 1);
        apb(1'b1, `FTM_CTRL_OFS, 32'h7);
        gap(467, 1);
        $display("t_low done");
    endtask

    task automatic t_late();
        repeat (21000) @(posedge pclk);
        t0 = toggles;
        apb(1'b1, `FTM_CTRL_OFS, 32'h3);
        repeat (4) @(negedge pclk);
        chk("late mark clear", t0 + 1, toggles);
        apb(1'b0, `FTM_CLRCNT_OFS, 32'h0);
        chk("clear count", toggles, rd);
        $display("t_late done");
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_high();
        t_low();
        t_late();
        final_report();
    end

    // Watchdog
    initial
    begin
        repeat (90000) @(posedge pclk);
        num_errors++;
        final_report();
    end
endmodule // fsk_tone_modulator_bench
`default_nettype wire
